// ---- verilog/sbs_consts.vh ----
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH

// Register byte offsets
`define SBS_OFF_CMD      8'h00
`define SBS_OFF_ABORT    8'h04
`define SBS_OFF_SRE      8'h08
`define SBS_OFF_STB      8'h0C
`define SBS_OFF_RESP     8'h10
`define SBS_OFF_ERR      8'h14
`define SBS_OFF_INT_STAT 8'h18
`define SBS_OFF_INT_CLR  8'h1C
`define SBS_OFF_INT_EN   8'h20

// Command opcodes in CMD[3:0]
`define SBS_OP_TST       4'h1
`define SBS_OP_WAI       4'h2
`define SBS_OP_INIT      4'h3
`define SBS_OP_RST       4'h4

// Status byte bit positions
`define SBS_STB_ERRQ     2
`define SBS_STB_MAV      4
`define SBS_STB_RQS      6

// Interrupt status bit positions
`define SBS_INT_TEST     0
`define SBS_INT_ERR      1
`define SBS_INT_SRQ      2
`define SBS_INT_MEAS     3
`define SBS_INT_W        4

// Error queue entries
`define SBS_ERR_TEST_NUM 8'h01
`define SBS_ERR_BUSY_NUM 8'h02
`define SBS_ERR_NONE     8'h00
`define SBS_ERRQ_DEPTH   4
`define SBS_ERRQ_AW      2
`define SBS_ERRQ_FULL    3'h4

// Self-test sequence length
`define SBS_TEST_STEPS   4'h8

// Reset values
`define SBS_RST_BYTE     8'h00
`define SBS_RST_WORD     32'h00000000

// AXI responses
`define SBS_RESP_OKAY    2'b00
`define SBS_RESP_SLVERR  2'b10

`endif

// ---- verilog/sbs_selftest.v ----
`timescale 1ns/1ns
`include "sbs_consts.vh"

// Walking-one check of a private scratch register; no user setting is touched
module sbs_selftest (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Control
  input  wire       start_in,
  input  wire       fault_in,
  // Result
  output reg        busy_out,
  output reg        done_out,
  output reg  [7:0] code_out
);

  reg [7:0] scratch_reg;
  reg [7:0] expect_reg;
  reg [3:0] step_reg;
  reg       chk_reg;

  always @(posedge clk) begin
    if (rst) begin
      busy_out    <= 1'b0;
      done_out    <= 1'b0;
      code_out    <= `SBS_RST_BYTE;
      scratch_reg <= `SBS_RST_BYTE;
      expect_reg  <= `SBS_RST_BYTE;
      step_reg    <= 4'h0;
      chk_reg     <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        code_out <= `SBS_RST_BYTE;
        step_reg <= 4'h0;
        chk_reg  <= 1'b0;
      end else if (busy_out) begin
        // Fault input corrupts bit 0 to prove the failure path
        scratch_reg <= (8'h01 << step_reg[2:0]) ^ {7'h00, fault_in};
        expect_reg  <= 8'h01 << step_reg[2:0];
        chk_reg     <= 1'b1;
        step_reg    <= step_reg + 4'h1;
        if (chk_reg && scratch_reg != expect_reg && code_out == `SBS_RST_BYTE)
          code_out <= {4'h0, step_reg};
        if (step_reg == `SBS_TEST_STEPS) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- verilog/sbs_status.v ----
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "sbs_consts.vh"

module sbs_status (
  // Clock and reset
  input  wire        CLK_IN,
  input  wire        RST_IN,
  // AXI4-Lite write address and data
  input  wire [7:0]  AXI_AWADDR_IN,
  input  wire        AXI_AWVALID_IN,
  output reg         AXI_AWREADY_OUT,
  input  wire [31:0] AXI_WDATA_IN,
  input  wire [3:0]  AXI_WSTRB_IN,
  input  wire        AXI_WVALID_IN,
  output reg         AXI_WREADY_OUT,
  // AXI4-Lite write response
  output reg  [1:0]  AXI_BRESP_OUT,
  output reg         AXI_BVALID_OUT,
  input  wire        AXI_BREADY_IN,
  // AXI4-Lite read
  input  wire [7:0]  AXI_ARADDR_IN,
  input  wire        AXI_ARVALID_IN,
  output reg         AXI_ARREADY_OUT,
  output reg  [31:0] AXI_RDATA_OUT,
  output reg  [1:0]  AXI_RRESP_OUT,
  output reg         AXI_RVALID_OUT,
  input  wire        AXI_RREADY_IN,
  // Instrument side
  input  wire [7:0]  STATUS_BITS_IN,
  input  wire        MEAS_DONE_IN,
  input  wire        TEST_FAULT_IN,
  output reg         MEAS_START_OUT,
  output reg         MEAS_ABORT_OUT,
  output reg         MEAS_ACTIVE_OUT,
  // Requests
  output reg         SRQ_OUT,
  output reg         IRQ_OUT
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_TEST = 3'b100;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg         aw_full_reg;
  reg         w_full_reg;
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg  [7:0]  sre_reg;
  reg  [7:0]  stb_reg;
  reg  [7:0]  resp_reg;
  reg         mav_reg;
  reg  [3:0]  int_stat_reg;
  reg  [3:0]  int_en_reg;
  reg  [7:0]  errq_num_reg [0:`SBS_ERRQ_DEPTH-1];
  reg  [7:0]  errq_desc_reg [0:`SBS_ERRQ_DEPTH-1];
  reg  [1:0]  errq_wr_reg;
  reg  [1:0]  errq_rd_reg;
  reg  [2:0]  errq_cnt_reg;
  reg  [2:0]  errq_cnt_next;
  reg         st_start_reg;
  reg         tst_refused;
  reg  [31:0] rd_data;
  reg         rd_hit;

  wire        st_busy;
  wire        st_done;
  wire [7:0]  st_code;

  // Write channel capture
  wire        aw_hs    = AXI_AWVALID_IN & AXI_AWREADY_OUT;
  wire        w_hs     = AXI_WVALID_IN & AXI_WREADY_OUT;
  wire [7:0]  wr_addr  = aw_hs ? AXI_AWADDR_IN : aw_addr_reg;
  wire [31:0] wr_data  = w_hs ? AXI_WDATA_IN : w_data_reg;
  wire [3:0]  wr_strb  = w_hs ? AXI_WSTRB_IN : w_strb_reg;
  wire        idle     = state_reg == ST_IDLE;
  // Command writes stall in the response phase until the block is idle
  wire        cmd_blk  = (wr_addr == `SBS_OFF_CMD) & ~idle;
  wire        wr_go    = (aw_full_reg | aw_hs) & (w_full_reg | w_hs) & ~AXI_BVALID_OUT & ~cmd_blk;
  wire        wr_hit   = wr_addr == `SBS_OFF_CMD || wr_addr == `SBS_OFF_ABORT || wr_addr == `SBS_OFF_SRE ||
                         wr_addr == `SBS_OFF_INT_CLR || wr_addr == `SBS_OFF_INT_EN;
  wire        cmd_go   = wr_go & (wr_addr == `SBS_OFF_CMD) & wr_strb[0];
  wire [3:0]  cmd_op   = wr_data[3:0];
  wire        abort_go = wr_go & (wr_addr == `SBS_OFF_ABORT);
  wire        rst_go   = cmd_go & (cmd_op == `SBS_OP_RST);
  wire        init_go  = cmd_go & (cmd_op == `SBS_OP_INIT);
  wire        wai_go   = cmd_go & (cmd_op == `SBS_OP_WAI);
  wire        tst_go   = cmd_go & (cmd_op == `SBS_OP_TST);
  wire        sre_wr   = wr_go & (wr_addr == `SBS_OFF_SRE) & wr_strb[0];
  wire        clr_wr   = wr_go & (wr_addr == `SBS_OFF_INT_CLR) & wr_strb[0];
  wire        en_wr    = wr_go & (wr_addr == `SBS_OFF_INT_EN) & wr_strb[0];

  // Read channel
  wire        ar_hs    = AXI_ARVALID_IN & AXI_ARREADY_OUT;
  wire        resp_pop = ar_hs & (AXI_ARADDR_IN == `SBS_OFF_RESP);
  wire        err_pop  = ar_hs & (AXI_ARADDR_IN == `SBS_OFF_ERR) & (errq_cnt_reg != 3'h0);

  // Measurement and abort
  wire        stop_meas = abort_go | rst_go;
  wire        meas_next = ~stop_meas & (init_go | (MEAS_ACTIVE_OUT & ~MEAS_DONE_IN));
  wire        meas_ev   = MEAS_ACTIVE_OUT & MEAS_DONE_IN & ~stop_meas;

  // Error queue push
  wire        st_fail   = st_done & (st_code != `SBS_RST_BYTE);
  wire        err_push  = tst_refused | st_fail;
  wire        push_ok   = err_push & (errq_cnt_reg != `SBS_ERRQ_FULL | err_pop);
  wire [7:0]  push_num  = st_fail ? `SBS_ERR_TEST_NUM : `SBS_ERR_BUSY_NUM;
  wire [7:0]  push_desc = st_fail ? st_code : `SBS_ERR_NONE;

  // Status byte, computed from next values so the request never lags
  wire [7:0]  sre_next = sre_wr ? wr_data[7:0] : sre_reg;
  wire        mav_next = st_done | (mav_reg & ~resp_pop);
  reg  [7:0]  stb_low;
  wire        rqs_next = |(stb_low & sre_next);
  wire [7:0]  stb_next = stb_low | ({7'h00, rqs_next} << `SBS_STB_RQS);

  // Interrupts
  wire [3:0]  int_ev   = {meas_ev, rqs_next & ~SRQ_OUT, err_push, st_done};
  wire [3:0]  int_stat_next = int_ev | (int_stat_reg & ~(clr_wr ? wr_data[3:0] : 4'h0));
  wire [3:0]  int_en_next   = en_wr ? wr_data[3:0] : int_en_reg;

  always @* begin
    stb_low = STATUS_BITS_IN;
    stb_low[`SBS_STB_ERRQ] = errq_cnt_next != 3'h0;
    stb_low[`SBS_STB_MAV]  = mav_next;
    stb_low[`SBS_STB_RQS]  = 1'b0;
  end

  always @* begin
    errq_cnt_next = errq_cnt_reg;
    if (push_ok && !err_pop)
      errq_cnt_next = errq_cnt_reg + 3'h1;
    else if (err_pop && !push_ok)
      errq_cnt_next = errq_cnt_reg - 3'h1;
  end

  // Command sequencer
  always @* begin
    state_next  = state_reg;
    tst_refused = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (tst_go) begin
          if (MEAS_ACTIVE_OUT)
            tst_refused = 1'b1;
          else
            state_next = ST_TEST;
        end else if (wai_go && MEAS_ACTIVE_OUT) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!meas_next)
          state_next = ST_IDLE;
      end
      ST_TEST: begin
        if (st_done)
          state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @* begin
    rd_data = `SBS_RST_WORD;
    rd_hit  = 1'b1;
    if (AXI_ARADDR_IN == `SBS_OFF_CMD) begin
      rd_data = {29'h0, state_reg};
    end else if (AXI_ARADDR_IN == `SBS_OFF_SRE) begin
      rd_data = {24'h0, sre_reg};
    end else if (AXI_ARADDR_IN == `SBS_OFF_STB) begin
      rd_data = {24'h0, stb_reg};
    end else if (AXI_ARADDR_IN == `SBS_OFF_RESP) begin
      rd_data = {24'h0, resp_reg};
    end else if (AXI_ARADDR_IN == `SBS_OFF_ERR) begin
      if (errq_cnt_reg != 3'h0)
        rd_data = {16'h0, errq_desc_reg[errq_rd_reg], errq_num_reg[errq_rd_reg]};
    end else if (AXI_ARADDR_IN == `SBS_OFF_INT_STAT) begin
      rd_data = {28'h0, int_stat_reg};
    end else if (AXI_ARADDR_IN == `SBS_OFF_INT_EN) begin
      rd_data = {28'h0, int_en_reg};
    end else if (AXI_ARADDR_IN == `SBS_OFF_ABORT || AXI_ARADDR_IN == `SBS_OFF_INT_CLR) begin
      rd_data = `SBS_RST_WORD;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Bus slave
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      AXI_AWREADY_OUT <= 1'b1;
      AXI_WREADY_OUT  <= 1'b1;
      AXI_BVALID_OUT  <= 1'b0;
      AXI_BRESP_OUT   <= `SBS_RESP_OKAY;
      AXI_ARREADY_OUT <= 1'b1;
      AXI_RVALID_OUT  <= 1'b0;
      AXI_RRESP_OUT   <= `SBS_RESP_OKAY;
      AXI_RDATA_OUT   <= `SBS_RST_WORD;
      aw_full_reg     <= 1'b0;
      w_full_reg      <= 1'b0;
      aw_addr_reg     <= `SBS_RST_BYTE;
      w_data_reg      <= `SBS_RST_WORD;
      w_strb_reg      <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_addr_reg     <= AXI_AWADDR_IN;
        AXI_AWREADY_OUT <= 1'b0;
      end
      if (w_hs) begin
        w_data_reg     <= AXI_WDATA_IN;
        w_strb_reg     <= AXI_WSTRB_IN;
        AXI_WREADY_OUT <= 1'b0;
      end
      if (wr_go) begin
        aw_full_reg    <= 1'b0;
        w_full_reg     <= 1'b0;
        AXI_BVALID_OUT <= 1'b1;
        AXI_BRESP_OUT  <= wr_hit ? `SBS_RESP_OKAY : `SBS_RESP_SLVERR;
      end else begin
        if (aw_hs)
          aw_full_reg <= 1'b1;
        if (w_hs)
          w_full_reg <= 1'b1;
      end
      if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
        AXI_BVALID_OUT  <= 1'b0;
        AXI_AWREADY_OUT <= 1'b1;
        AXI_WREADY_OUT  <= 1'b1;
      end
      if (ar_hs) begin
        AXI_ARREADY_OUT <= 1'b0;
        AXI_RVALID_OUT  <= 1'b1;
        AXI_RDATA_OUT   <= rd_data;
        AXI_RRESP_OUT   <= rd_hit ? `SBS_RESP_OKAY : `SBS_RESP_SLVERR;
      end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
        AXI_RVALID_OUT  <= 1'b0;
        AXI_ARREADY_OUT <= 1'b1;
      end
    end
  end

  // Block state
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg       <= ST_IDLE;
      sre_reg         <= `SBS_RST_BYTE;
      stb_reg         <= `SBS_RST_BYTE;
      resp_reg        <= `SBS_RST_BYTE;
      mav_reg         <= 1'b0;
      int_stat_reg    <= 4'h0;
      int_en_reg      <= 4'h0;
      errq_wr_reg     <= 2'h0;
      errq_rd_reg     <= 2'h0;
      errq_cnt_reg    <= 3'h0;
      st_start_reg    <= 1'b0;
      MEAS_START_OUT  <= 1'b0;
      MEAS_ABORT_OUT  <= 1'b0;
      MEAS_ACTIVE_OUT <= 1'b0;
      SRQ_OUT         <= 1'b0;
      IRQ_OUT         <= 1'b0;
    end else begin
      state_reg       <= state_next;
      // Device reset command leaves mask, queues and response alone
      sre_reg         <= sre_next;
      stb_reg         <= stb_next;
      SRQ_OUT         <= rqs_next;
      mav_reg         <= mav_next;
      if (st_done)
        resp_reg <= st_code;
      st_start_reg    <= tst_go & ~MEAS_ACTIVE_OUT & idle & ~st_busy;
      MEAS_START_OUT  <= init_go & ~MEAS_ACTIVE_OUT & ~stop_meas;
      MEAS_ABORT_OUT  <= stop_meas & MEAS_ACTIVE_OUT;
      MEAS_ACTIVE_OUT <= meas_next;
      int_stat_reg    <= int_stat_next;
      int_en_reg      <= int_en_next;
      IRQ_OUT         <= |(int_stat_next & int_en_next);
      errq_cnt_reg    <= errq_cnt_next;
      if (push_ok)
        errq_wr_reg <= errq_wr_reg + 2'h1;
      if (err_pop)
        errq_rd_reg <= errq_rd_reg + 2'h1;
    end
  end

  always @(posedge CLK_IN) begin
    if (push_ok) begin
      errq_num_reg[errq_wr_reg]  <= push_num;
      errq_desc_reg[errq_wr_reg] <= push_desc;
    end
  end

  // Test runs on its own scratch storage only
  sbs_selftest u_selftest (
    .clk      (CLK_IN),
    .rst      (RST_IN),
    .start_in (st_start_reg),
    .fault_in (TEST_FAULT_IN),
    .busy_out (st_busy),
    .done_out (st_done),
    .code_out (st_code)
  );

endmodule

// ---- bench/sbs_meas_model.sv ----
`timescale 1ns/1ns
module sbs_meas_model #(
  parameter [7:0] LEN = 8'h28
) (
  input  wire clk_in,
  input  wire rst_in,
  input  wire start_in,
  input  wire abort_in,
  output reg  done_out
);
  reg [7:0] count_reg;
  // Fixed measurement time, one-cycle finish pulse
  always @(posedge clk_in) begin
    done_out <= 1'h0;
    if (rst_in || abort_in) begin
      count_reg <= 8'h00;
    end else if (start_in) begin
      count_reg <= LEN;
    end else if (count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
      done_out  <= (count_reg == 8'h01);
    end
  end
endmodule

// ---- bench/sbs_status_checker.sv ----
`timescale 1ns/1ns
`include "sbs_consts.vh"
module sbs_status_checker (
  input wire        CLK_IN,
  input wire        RST_IN,
  input wire [7:0]  AXI_AWADDR_IN,
  input wire        AXI_AWVALID_IN,
  input wire        AXI_AWREADY_OUT,
  input wire [31:0] AXI_WDATA_IN,
  input wire        AXI_WVALID_IN,
  input wire        AXI_WREADY_OUT,
  input wire [1:0]  AXI_BRESP_OUT,
  input wire        AXI_BVALID_OUT,
  input wire        AXI_BREADY_IN,
  input wire        AXI_ARVALID_IN,
  input wire        AXI_ARREADY_OUT,
  input wire [31:0] AXI_RDATA_OUT,
  input wire        AXI_RVALID_OUT,
  input wire        AXI_RREADY_IN,
  input wire        MEAS_START_OUT,
  input wire        MEAS_ABORT_OUT,
  input wire        MEAS_ACTIVE_OUT,
  input wire        SRQ_OUT,
  input wire        IRQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  reg  wai_seen_reg;
  reg  cmd_held_reg;
  wire wr_take  = AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
  wire cmd_take = wr_take && (AXI_AWADDR_IN == `SBS_OFF_CMD);
  // Wait accepted during a measurement
  always @(posedge CLK_IN) begin
    if (RST_IN || !MEAS_ACTIVE_OUT) begin
      wai_seen_reg <= 1'h0;
    end else if (cmd_take && AXI_WDATA_IN[3:0] == `SBS_OP_WAI) begin
      wai_seen_reg <= 1'h1;
    end
  end
  // Later command owes its response until the measurement ends
  always @(posedge CLK_IN) begin
    if (RST_IN || (AXI_BVALID_OUT && AXI_BREADY_IN)) begin
      cmd_held_reg <= 1'h0;
    end else if (cmd_take && wai_seen_reg) begin
      cmd_held_reg <= 1'h1;
    end
  end
  sequence s_reg_write; wr_take && !cmd_take; endsequence
  sequence s_rd_take; AXI_ARVALID_IN && AXI_ARREADY_OUT; endsequence
  sequence s_start_done; !MEAS_START_OUT && MEAS_ACTIVE_OUT; endsequence
  property p_reset_quiet; $fell(RST_IN) |-> !SRQ_OUT && !IRQ_OUT; endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("request high after reset");
  property p_wr_answer; s_reg_write |=> AXI_BVALID_OUT; endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  property p_b_hold; AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT); endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_rd_answer; s_rd_take |=> AXI_RVALID_OUT; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read response late");
  property p_r_hold; AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT); endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  property p_start_pulse; MEAS_START_OUT |=> s_start_done; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse wrong");
  property p_abort_idle; MEAS_ABORT_OUT |-> ##[0:1] !MEAS_ACTIVE_OUT; endproperty
  a_abort_idle: assert property (p_abort_idle)
    else $error("abort left activity");
  property p_wait_hold; cmd_held_reg && MEAS_ACTIVE_OUT |-> !AXI_BVALID_OUT; endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("command done while busy");
endmodule
bind sbs_status sbs_status_checker u_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .AXI_AWADDR_IN(AXI_AWADDR_IN), .AXI_AWVALID_IN(AXI_AWVALID_IN),
  .AXI_AWREADY_OUT(AXI_AWREADY_OUT), .AXI_WDATA_IN(AXI_WDATA_IN), .AXI_WVALID_IN(AXI_WVALID_IN),
  .AXI_WREADY_OUT(AXI_WREADY_OUT),
  .AXI_BRESP_OUT(AXI_BRESP_OUT), .AXI_BVALID_OUT(AXI_BVALID_OUT), .AXI_BREADY_IN(AXI_BREADY_IN),
  .AXI_ARVALID_IN(AXI_ARVALID_IN), .AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RDATA_OUT(AXI_RDATA_OUT),
  .AXI_RVALID_OUT(AXI_RVALID_OUT), .AXI_RREADY_IN(AXI_RREADY_IN), .MEAS_START_OUT(MEAS_START_OUT),
  .MEAS_ABORT_OUT(MEAS_ABORT_OUT), .MEAS_ACTIVE_OUT(MEAS_ACTIVE_OUT), .SRQ_OUT(SRQ_OUT), .IRQ_OUT(IRQ_OUT)
);

// ---- bench/status_byte_service_request_test.sv ----
`timescale 1ns/1ns
`include "sbs_consts.vh"
module status_byte_service_request_test;
  logic        clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, fault = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, stat = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, start, abort, active, srq, irq, done;
  int          n_fail = 0;
  int          checks_done = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  sbs_status DUT (
    .CLK_IN(clk), .RST_IN(rst), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
    .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
    .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
    .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .STATUS_BITS_IN(stat), .MEAS_DONE_IN(done),
    .TEST_FAULT_IN(fault), .MEAS_START_OUT(start), .MEAS_ABORT_OUT(abort), .MEAS_ACTIVE_OUT(active),
    .SRQ_OUT(srq), .IRQ_OUT(irq)
  );
  sbs_meas_model #(.LEN(8'h28)) u_meas (.clk_in(clk), .rst_in(rst), .start_in(start), .abort_in(abort),
    .done_out(done));
  task give_verdict;
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task guard(input int i);
    chk(i < 1000, 1'h1);
    if (i >= 1000) give_verdict;
  endtask
  task w(input logic [7:0] a, input logic [31:0] v);
    int i;
    awaddr  <= a;
    awvalid <= 1'h1;
    wdata   <= v;
    wvalid  <= 1'h1;
    for (i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'h1;
    end
    guard(i);
    chk(bresp, `SBS_RESP_OKAY);
    bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    int i;
    araddr  <= a;
    arvalid <= 1'h1;
    for (i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'h1;
    end
    guard(i);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task wait_irq;
    int i;
    for (i = 0; i < 1000 && irq !== 1'h1; i++) @(posedge clk);
    guard(i);
    @(posedge clk);
  endtask
  task t_mask;
    chk(srq, 1'h0);
    chk(irq, 1'h0);
    rc(`SBS_OFF_SRE, 32'h0);
    w(`SBS_OFF_SRE, 32'hA5);
    rc(`SBS_OFF_SRE, 32'hA5);
    w(`SBS_OFF_SRE, 32'hFF);
    rc(`SBS_OFF_SRE, 32'hFF);
    w(`SBS_OFF_SRE, 32'h00);
    rc(`SBS_OFF_SRE, 32'h00);
    rd(8'h40);
    chk(r, `SBS_RESP_SLVERR);
  endtask
  task t_stb;
    stat <= 8'hAB;
    @(posedge clk);
    rc(`SBS_OFF_STB, 32'hAB);
    chk(srq, 1'h0);
    w(`SBS_OFF_SRE, 32'h02);
    chk(srq, 1'h1);
    rc(`SBS_OFF_STB, 32'hEB);
    stat <= 8'hA9;
    repeat (2) @(posedge clk);
    chk(srq, 1'h0);
    rc(`SBS_OFF_STB, 32'hA9);
    stat <= 8'h00;
  endtask
  task t_pass;
    w(`SBS_OFF_INT_CLR, 32'h1F);
    w(`SBS_OFF_INT_EN, 32'h01);
    w(`SBS_OFF_SRE, 32'h10);
    w(`SBS_OFF_CMD, {28'h0, `SBS_OP_TST});
    wait_irq;
    chk(srq, 1'h1);
    rc(`SBS_OFF_STB, 32'h50);
    rc(`SBS_OFF_RESP, 32'h0);
    @(posedge clk);
    chk(srq, 1'h0);
    w(`SBS_OFF_INT_EN, 32'h0);
    chk(irq, 1'h0);
    rc(`SBS_OFF_INT_STAT, 32'h05);
    w(`SBS_OFF_INT_CLR, 32'h1F);
    rc(`SBS_OFF_INT_STAT, 32'h0);
  endtask
  task t_fail;
    fault <= 1'h1;
    w(`SBS_OFF_SRE, 32'h04);
    w(`SBS_OFF_INT_EN, 32'h01);
    w(`SBS_OFF_CMD, {28'h0, `SBS_OP_TST});
    wait_irq;
    chk(srq, 1'h1);
    rc(`SBS_OFF_STB, 32'h54);
    rc(`SBS_OFF_RESP, 32'h01);
    rc(`SBS_OFF_ERR, 32'h0101);
    rc(`SBS_OFF_ERR, 32'h0);
    rc(`SBS_OFF_SRE, 32'h04);
    fault <= 1'h0;
    w(`SBS_OFF_INT_EN, 32'h0);
  endtask
  task t_meas;
    w(`SBS_OFF_CMD, {28'h0, `SBS_OP_INIT});
    chk(active, 1'h1);
    w(`SBS_OFF_CMD, {28'h0, `SBS_OP_TST});
    rc(`SBS_OFF_ERR, 32'h0002);
    rc(`SBS_OFF_CMD, 32'h1);
    w(`SBS_OFF_CMD, {28'h0, `SBS_OP_WAI});
    rc(`SBS_OFF_CMD, 32'h2);
    w(`SBS_OFF_CMD, 32'h0);
    chk(active, 1'h0);
    w(`SBS_OFF_CMD, {28'h0, `SBS_OP_INIT});
    w(`SBS_OFF_ABORT, 32'h0);
    chk(active, 1'h0);
    w(`SBS_OFF_CMD, {28'h0, `SBS_OP_RST});
    rc(`SBS_OFF_SRE, 32'h04);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_mask;
    t_stb;
    t_pass;
    t_fail;
    t_meas;
    give_verdict;
  end
endmodule
